// ### hw/hmac_map.vh
`ifndef HMAC_MAP_VH
`define HMAC_MAP_VH
// register byte offsets
`define HMAC_OFF_CTRL 8'h00
`define HMAC_OFF_OPA 8'h04
`define HMAC_OFF_OPB 8'h08
`define HMAC_OFF_ACC0 8'h0c
`define HMAC_OFF_ACC1 8'h10
`define HMAC_OFF_ACC2 8'h14
// control field positions
`define HMAC_CTL_SUS 0
`define HMAC_CTL_OPCS 1
`define HMAC_CTL_MSUB 2
`define HMAC_CTL_MMAC 3
`define HMAC_CTL_SQU 4
`define HMAC_CTL_CLR 5
`define HMAC_CTL_MCW 6
`define HMAC_CTL_OF 7
// reset values
`define HMAC_CTRL_RST 8'h00
`define HMAC_WORD_RST 16'h0000
`define HMAC_ACC_RST 48'h000000000000
`endif

// ### hw/hmac_mult.v
`timescale 1ns/1ns
`default_nettype none
// combinational 16x16 multiply core, signed or unsigned
module hmac_mult (
  input wire [15:0] a, // operand a
  input wire [15:0] b, // operand b
  input wire sgn, // signed operands
  output reg [31:0] prod // product, sign- or zero-extended to 48 bits in caller
);
  wire signed [16:0] a_x;
  wire signed [16:0] b_x;
  wire signed [33:0] p_x;
  // sign or zero extend then multiply
  assign a_x = {sgn & a[15], a};
  assign b_x = {sgn & b[15], b};
  assign p_x = a_x * b_x;
  always @(*) begin
    prod = p_x[31:0];
  end
endmodule
`default_nettype wire

// ### hw/hmac_top.v
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "hmac_map.vh"
module hmac_top (
  input wire aclk, // 20 mhz system clock
  input wire aresetn, // synchronous reset, active low
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready // read data ready
);
  localparam [1:0] RESP_OK = 2'b00;
  localparam [1:0] RESP_ERR = 2'b10;
  reg [7:0] ctrl_q;
  reg [15:0] opa_q;
  reg [15:0] opb_q;
  reg [47:0] acc_q;
  reg [47:0] acc_d;
  reg of_d;
  reg aw_q;
  reg w_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg go_q;
  wire [31:0] prod;
  wire sgn;
  wire do_wr;
  wire [48:0] sum_u;
  wire [48:0] dif_u;
  wire [48:0] sum_z;
  wire [48:0] dif_z;
  wire [47:0] prod_x;
  // decode a byte address to register match
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr[7:2] == off[7:2]);
    end
  endfunction
  // any of the six register words
  function mapped;
    input [7:0] addr;
    begin
      mapped = hit(addr, `HMAC_OFF_CTRL) || hit(addr, `HMAC_OFF_OPA) ||
        hit(addr, `HMAC_OFF_OPB) || hit(addr, `HMAC_OFF_ACC0) ||
        hit(addr, `HMAC_OFF_ACC1) || hit(addr, `HMAC_OFF_ACC2);
    end
  endfunction
  // does this operand write complete the operand set
  function starts;
    input is_b;
    input two;
    input squ;
    begin
      starts = squ ? ~is_b : (is_b == two);
    end
  endfunction
  // bus handshakes: each channel captured once per write
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_wr = aw_q & w_q & ~s_axi_bvalid;
  assign sgn = ~ctrl_q[`HMAC_CTL_SUS];
  // multiplier, squaring reuses operand a
  hmac_mult u_mult (
    .a(opa_q),
    .b(ctrl_q[`HMAC_CTL_SQU] ? opa_q : opb_q),
    .sgn(sgn),
    .prod(prod)
  );
  assign prod_x = sgn ? {{16{prod[31]}}, prod} : {16'h0000, prod};
  assign sum_u = {acc_q[47], acc_q} + {prod_x[47], prod_x};
  assign dif_u = {acc_q[47], acc_q} - {prod_x[47], prod_x};
  // unsigned carry and borrow out of the 48-bit accumulator
  assign sum_z = {1'b0, acc_q} + {1'b0, prod_x};
  assign dif_z = {1'b0, acc_q} - {1'b0, prod_x};
  // operation select and overflow detect
  always @(*) begin
    acc_d = acc_q;
    of_d = 1'b0;
    if (ctrl_q[`HMAC_CTL_MMAC] && !ctrl_q[`HMAC_CTL_MSUB]) begin
      acc_d = sum_u[47:0];
      of_d = sgn ? (sum_u[48] != sum_u[47]) : sum_z[48];
    end else if (ctrl_q[`HMAC_CTL_MSUB]) begin
      acc_d = dif_u[47:0];
      of_d = sgn ? (dif_u[48] != dif_u[47]) : dif_z[48];
      if (!ctrl_q[`HMAC_CTL_MMAC] && sgn) begin
        acc_d = 48'h000000000000 - prod_x; // negate
        of_d = 1'b0;
      end
    end else begin
      acc_d = prod_x; // plain product
    end
  end
  // write channel capture
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? RESP_OK : RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // register file, operand load and compute
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `HMAC_CTRL_RST;
      opa_q <= `HMAC_WORD_RST;
      opb_q <= `HMAC_WORD_RST;
      acc_q <= `HMAC_ACC_RST;
      go_q <= 1'b0;
    end else begin
      // start strobe lasts one cycle, clear bit is never stored and reads back zero
      go_q <= 1'b0;
      ctrl_q[`HMAC_CTL_CLR] <= 1'b0;
      if (go_q) begin
        acc_q <= acc_d;
        if (of_d) begin
          ctrl_q[`HMAC_CTL_OF] <= 1'b1;
        end
      end
      // control write, a hardware overflow set wins over a clear
      if (do_wr && hit(awaddr_q, `HMAC_OFF_CTRL) && wstrb_q[0]) begin
        ctrl_q[6:0] <= wdata_q[6:0];
        ctrl_q[`HMAC_CTL_CLR] <= 1'b0;
        if (!wdata_q[`HMAC_CTL_OF] && !(go_q && of_d)) begin
          ctrl_q[`HMAC_CTL_OF] <= 1'b0;
        end
        if (wdata_q[`HMAC_CTL_CLR]) begin
          opa_q <= `HMAC_WORD_RST;
          opb_q <= `HMAC_WORD_RST;
          acc_q <= `HMAC_ACC_RST;
        end
      end
      if (do_wr && wstrb_q[1:0] == 2'b11) begin
        if (hit(awaddr_q, `HMAC_OFF_OPA)) begin
          opa_q <= wdata_q[15:0];
          go_q <= starts(1'b0, ctrl_q[`HMAC_CTL_OPCS], ctrl_q[`HMAC_CTL_SQU]);
        end
        if (hit(awaddr_q, `HMAC_OFF_OPB)) begin
          opb_q <= wdata_q[15:0];
          go_q <= starts(1'b1, ctrl_q[`HMAC_CTL_OPCS], ctrl_q[`HMAC_CTL_SQU]);
        end
        // accumulator write option
        if (ctrl_q[`HMAC_CTL_MCW]) begin
          if (hit(awaddr_q, `HMAC_OFF_ACC0)) acc_q[15:0] <= wdata_q[15:0];
          if (hit(awaddr_q, `HMAC_OFF_ACC1)) acc_q[31:16] <= wdata_q[15:0];
          if (hit(awaddr_q, `HMAC_OFF_ACC2)) acc_q[47:32] <= wdata_q[15:0];
        end
      end
    end
  end
  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OK;
      if (hit(s_axi_araddr, `HMAC_OFF_CTRL)) s_axi_rdata <= {24'h000000, ctrl_q};
      else if (hit(s_axi_araddr, `HMAC_OFF_OPA)) s_axi_rdata <= {16'h0000, opa_q};
      else if (hit(s_axi_araddr, `HMAC_OFF_OPB)) s_axi_rdata <= {16'h0000, opb_q};
      else if (hit(s_axi_araddr, `HMAC_OFF_ACC0)) s_axi_rdata <= {16'h0000, acc_q[15:0]};
      else if (hit(s_axi_araddr, `HMAC_OFF_ACC1)) s_axi_rdata <= {16'h0000, acc_q[31:16]};
      else if (hit(s_axi_araddr, `HMAC_OFF_ACC2)) s_axi_rdata <= {16'h0000, acc_q[47:32]};
      else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= RESP_ERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### test/hmac_chk.sv
`timescale 1ns/1ns
`default_nettype none
// handshake timing and read data checks at the register bus
module hmac_chk (
  input wire logic aclk, // clk
  input wire logic aresetn, // rst
  input wire logic s_axi_awvalid, // aw
  input wire logic s_axi_awready, // aw
  input wire logic s_axi_wvalid, // w
  input wire logic s_axi_wready, // w
  input wire logic s_axi_bvalid, // b
  input wire logic s_axi_bready, // b
  input wire logic s_axi_arvalid, // ar
  input wire logic s_axi_arready, // ar
  input wire logic [31:0] s_axi_rdata, // r
  input wire logic s_axi_rvalid, // r
  input wire logic s_axi_rready // r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // request takes and answer steps
  sequence s_wt; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rt; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_bl; !s_axi_bvalid ##1 s_axi_bvalid; endsequence
  property p_bv; s_wt |=> s_bl; endproperty
  a_bv: assert property (p_bv) else $error("write answer late");
  property p_rv; s_rt |=> s_axi_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read answer late");
  property p_bd; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bd: assert property (p_bd) else $error("write answer stuck");
  property p_rd; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read answer stuck");
  property p_wr; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wr: assert property (p_wr) else $error("write taken early");
  property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar: assert property (p_ar) else $error("read taken early");
  property p_rz; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_rz: assert property (p_rz) else $error("upper read bits");
  property p_rq; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid); endproperty
  a_rq: assert property (p_rq) else $error("unasked read");
endmodule
bind hmac_top hmac_chk u_chk (.*);
`default_nettype wire

// ### test/hmac_cpu.sv
`timescale 1ns/1ns
`default_nettype none
// processor core model wrapped around the unit
module hmac_cpu (
  input wire logic aclk, // clk
  input wire logic aresetn // rst
);
  logic [7:0] aa = 8'h00;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  wire awr, wr, bv, arr, rv;
  wire [1:0] rr;
  wire [1:0] br;
  logic [1:0] wresp = 2'b00;
  wire [31:0] rd;
  hmac_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
  // one register write, each channel released when taken
  task wt(input logic [7:0] a, input logic [15:0] d);
    @(posedge aclk);
    aa <= a;
    wd <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    wresp = br;
    bry <= 1'b0;
  endtask
  // one register read
  task rt(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
    @(posedge aclk);
    ra <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rd;
    e = rr;
    rry <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/hmac_top_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "hmac_map.vh"
module hmac_top_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  int err_count = 0;
  int comparisons = 0;
  logic [31:0] d;
  logic [1:0] e;
  logic [47:0] acc;
  // control, operand a, operand b, expected accumulator
  logic [87:0] rows [10] = '{88'h03_ffff_ffff_0000fffe0001, 88'h0b_0002_0003_0000fffe0007,
    88'h0f_0001_0007_0000fffe0000, 88'h02_ffff_0003_fffffffffffd,
    88'h0a_0002_0002_000000000001, 88'h0e_ffff_0001_000000000002,
    88'h06_0003_0004_fffffffffff4, 88'h12_fffe_0000_000000000004,
    88'h01_0005_0000_000000000014, 88'h07_0002_0003_00000000000e};
  hmac_cpu u_cpu (.aclk(aclk), .aresetn(aresetn));
  always #25 aclk = ~aclk;
  // compare and count
  task chk(input string n, input logic [47:0] x, input logic [47:0] g);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  // gather the three accumulator words
  task racc;
    u_cpu.rt(`HMAC_OFF_ACC0, d, e);
    acc[15:0] = d[15:0];
    u_cpu.rt(`HMAC_OFF_ACC1, d, e);
    acc[31:16] = d[15:0];
    u_cpu.rt(`HMAC_OFF_ACC2, d, e);
    acc[47:32] = d[15:0];
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #1000000;
    err_count++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    u_cpu.rt(`HMAC_OFF_CTRL, d, e);
    chk("reset control", 48'h0, {14'h0, d, e});
    racc;
    chk("reset acc", 48'h0, acc);
    $display("reset test done");
    foreach (rows[i]) begin
      u_cpu.wt(`HMAC_OFF_CTRL, {8'h00, rows[i][87:80]});
      u_cpu.wt(`HMAC_OFF_OPA, rows[i][79:64]);
      if (rows[i][81] && !rows[i][84]) u_cpu.wt(`HMAC_OFF_OPB, rows[i][63:48]);
      racc;
      chk("acc", rows[i][47:0], acc);
    end
    $display("operation rows done");
    u_cpu.wt(`HMAC_OFF_CTRL, 16'h0022);
    racc;
    chk("cleared acc", 48'h0, acc);
    u_cpu.rt(`HMAC_OFF_CTRL, d, e);
    chk("clear bit", 48'h02, {16'h0, d});
    u_cpu.rt(`HMAC_OFF_OPA, d, e);
    chk("cleared opa", 48'h0, {16'h0, d});
    $display("clear test done");
    u_cpu.wt(`HMAC_OFF_CTRL, 16'h000f);
    u_cpu.wt(`HMAC_OFF_OPA, 16'h0001);
    u_cpu.wt(`HMAC_OFF_OPB, 16'h0001);
    u_cpu.rt(`HMAC_OFF_CTRL, d, e);
    chk("overflow set", 48'h8f, {16'h0, d});
    u_cpu.wt(`HMAC_OFF_CTRL, 16'h000f);
    u_cpu.rt(`HMAC_OFF_CTRL, d, e);
    chk("overflow cleared", 48'h0f, {16'h0, d});
    $display("overflow test done");
    u_cpu.wt(`HMAC_OFF_CTRL, 16'h0040);
    chk("write resp", 48'h0, {46'h0, u_cpu.wresp});
    u_cpu.wt(`HMAC_OFF_ACC0, 16'hffff);
    u_cpu.wt(`HMAC_OFF_ACC1, 16'hffff);
    u_cpu.wt(`HMAC_OFF_ACC2, 16'h7fff);
    racc;
    chk("preset acc", 48'h7fffffffffff, acc);
    u_cpu.wt(`HMAC_OFF_CTRL, 16'h0008);
    u_cpu.wt(`HMAC_OFF_ACC0, 16'h0000);
    u_cpu.wt(`HMAC_OFF_OPA, 16'h0001);
    racc;
    chk("signed overflow acc", 48'h800000000000, acc);
    u_cpu.rt(`HMAC_OFF_CTRL, d, e);
    chk("signed overflow flag", 48'h88, {16'h0, d});
    $display("write option test done");
    u_cpu.rt(8'h18, d, e);
    chk("unmapped read", 48'h2, {14'h0, d, e});
    u_cpu.wt(8'h18, 16'h1234);
    chk("unmapped write", 48'h2, {46'h0, u_cpu.wresp});
    $display("unmapped test done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    u_cpu.rt(`HMAC_OFF_CTRL, d, e);
    chk("mid reset control", 48'h0, {14'h0, d, e});
    u_cpu.rt(`HMAC_OFF_OPA, d, e);
    chk("mid reset opa", 48'h0, {16'h0, d});
    racc;
    chk("mid reset acc", 48'h0, acc);
    $display("mid reset test done");
    end_of_test;
  end
endmodule
`default_nettype wire
